/* verilog/pmcrb_config_bank.v */
// Protected configuration register bank with its pin and switch steering.
// Assumes a synchronous 8-bit register port: one-cycle write/read strobes.
// How it works
// - Hold-time bit picks 8 s when clear, 15 s when set, resetting clear.
// - Output pin 2 is open-drain when its drive bit is clear, push-pull when set; resets set.
// - Io-pin-1 role clear makes io pin 1 an open-drain output and pin 2 independent.
// - Io-pin-1 role set makes io pin 1 an input whose level drives output pin 2.
// - The power-good delay code picks 10, 20, 50 or 150 ms, resetting to 01.
// - The delay applies only to power-good rising; falling passes undelayed.
// - Supervisor bit clear selects wide thresholds and no overvoltage watch.
// - Supervisor bit set selects tight thresholds and enables overvoltage watch.
// - Warm-reset enable clear makes io pin 3 a general-purpose output.
// - Warm-reset enable set, its reset state, makes io pin 3 a buck 1/2 warm-reset input.
// - Switch-3 limit in bits 3-2 picks 100/200/500/1000 mA, resetting 00.
// - Switch-2 limit in bits 1-0 picks 100/200/500/1000 mA, resetting 00.
// - A set power-fail-off bit turns its switch off while the power-fail flag is low.
// - A set discharge bit discharges its switch output whenever the switch is off.
// - Each protected write needs a fresh unlock key; the key register reads zero.
// - While warm reset is enabled the io-pin-3 enable bit has no effect.
`timescale 1ns/1ps
`include "pmcrb_defines.vh"
module pmcrb_config_bank (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output wire o_wr_rejected,
  input wire [2:0] i_ls_en,
  input wire i_power_fail_flag_n,
  input wire i_pgood_raw,
  input wire i_io_pin_one_in,
  input wire i_io_pin_three_in,
  input wire [2:0] i_en2_pin_bits,
  output wire o_io_pin_one_out,
  output wire o_io_pin_one_oe_n,
  output wire o_out_pin_two_out,
  output wire o_out_pin_two_oe_n,
  output wire o_io_pin_three_out,
  output wire o_io_pin_three_oe_n,
  output wire o_buck12_warm_reset,
  output wire o_pgood,
  output wire o_hold_15s,
  output wire o_tight_thresholds,
  output wire o_ov_monitor_en,
  output wire [1:0] o_undervoltage_lockout_level,
  output wire o_lockout_hysteresis_sel,
  output wire [1:0] o_switch3_current_limit,
  output wire [1:0] o_switch2_current_limit,
  output wire [2:0] o_ls_on,
  output wire [2:0] o_ls_discharge
);
  reg [7:0] pinsup_r;
  reg [7:0] rstlim_r;
  reg [7:0] pfdch_r;
  reg unlocked_r;
  reg rej_r;
  wire prot_hit;
  wire [2:0] pf_off;

  //////////////////////////////////////////////////////////////////////////////
  // Register port

  assign prot_hit = (i_addr == `PMCRB_ADDR_PINSUP) || (i_addr == `PMCRB_ADDR_RSTLIM) ||
                    (i_addr == `PMCRB_ADDR_PFDCH) || (i_addr == `PMCRB_ADDR_ENABLE2);

  // Unlock arms exactly one following write; any other write disarms it
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      pinsup_r <= `PMCRB_RST_PINSUP;
      rstlim_r <= `PMCRB_RST_RSTLIM;
      pfdch_r <= `PMCRB_RST_PFDCH;
      unlocked_r <= 1'b0;
      rej_r <= 1'b0;
    end else begin
      rej_r <= 1'b0;
      if (i_wr) begin
        unlocked_r <= (i_addr == `PMCRB_ADDR_UNLOCK) &&
                      (i_wdata == `PMCRB_UNLOCK_KEY);
        if (prot_hit && !unlocked_r) begin
          rej_r <= 1'b1;
        end else if (unlocked_r) begin
          case (i_addr)
            `PMCRB_ADDR_PINSUP: pinsup_r <= i_wdata & `PMCRB_MASK_PINSUP;
            `PMCRB_ADDR_RSTLIM: rstlim_r <= i_wdata & `PMCRB_MASK_RSTLIM;
            `PMCRB_ADDR_PFDCH: pfdch_r <= i_wdata & `PMCRB_MASK_PFDCH;
            default: ;
          endcase
        end
      end
    end
  end

  // Read data registered; unknown addresses and the key read as zero
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `PMCRB_ADDR_PINSUP: o_rdata <= pinsup_r;
        `PMCRB_ADDR_RSTLIM: o_rdata <= rstlim_r & `PMCRB_MASK_RSTLIM;
        `PMCRB_ADDR_PFDCH: o_rdata <= pfdch_r & `PMCRB_MASK_PFDCH;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  assign o_wr_rejected = rej_r;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration outputs

  assign o_hold_15s = pinsup_r[`PMCRB_BIT_RST_TIME];
  assign o_tight_thresholds = pinsup_r[`PMCRB_BIT_TIGHT];
  assign o_ov_monitor_en = pinsup_r[`PMCRB_BIT_TIGHT];
  assign o_undervoltage_lockout_level = pinsup_r[1:0];
  assign o_lockout_hysteresis_sel = rstlim_r[`PMCRB_BIT_HYST];
  assign o_switch3_current_limit = rstlim_r[3:2];
  assign o_switch2_current_limit = rstlim_r[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Pins; an _oe_n low means the pin is driven

  // Io pin 1: open-drain output from enable bit, or input when role set
  assign o_io_pin_one_out = 1'b0;
  assign o_io_pin_one_oe_n = pinsup_r[`PMCRB_BIT_IO1_ROLE] | i_en2_pin_bits[0];

  // Pin 2 level source: io pin 1 input when role set, else its own enable bit
  wire out2_level = pinsup_r[`PMCRB_BIT_IO1_ROLE] ? i_io_pin_one_in
                                                  : i_en2_pin_bits[1];
  // Push-pull drives both levels; open-drain only pulls low
  assign o_out_pin_two_out = out2_level;
  assign o_out_pin_two_oe_n = pinsup_r[`PMCRB_BIT_OUT2_PP] ? 1'b0 : out2_level;

  // Io pin 3 released as an input while warm reset owns it
  assign o_io_pin_three_out = 1'b0;
  assign o_io_pin_three_oe_n = rstlim_r[`PMCRB_BIT_WARM_RST] | i_en2_pin_bits[2];
  assign o_buck12_warm_reset = rstlim_r[`PMCRB_BIT_WARM_RST] & ~i_io_pin_three_in;

  //////////////////////////////////////////////////////////////////////////////
  // Load switches and power good

  assign pf_off = pfdch_r[5:3] & {3{~i_power_fail_flag_n}};
  assign o_ls_on = i_ls_en & ~pf_off;
  assign o_ls_discharge = pfdch_r[2:0] & ~o_ls_on;

  // Delay counts derived from ms figures; long counts in this submodule
  pmcrb_pgood_delay #(
    .DLY0(`PMCRB_PGD_MS0 * `PMCRB_MS_CYCLES),
    .DLY1(`PMCRB_PGD_MS1 * `PMCRB_MS_CYCLES),
    .DLY2(`PMCRB_PGD_MS2 * `PMCRB_MS_CYCLES),
    .DLY3(`PMCRB_PGD_MS3 * `PMCRB_MS_CYCLES)
  ) u_pgd (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_sel(pinsup_r[`PMCRB_BIT_PGD_HI:`PMCRB_BIT_PGD_LO]),
    .i_pgood_raw(i_pgood_raw),
    .o_pgood(o_pgood)
  );
endmodule // pmcrb_config_bank

/* verilog/pmcrb_defines.vh */
// Constants for the protected configuration register bank.
// Assumes an 8-bit register port addressed by sub-address, one write per unlock.
`ifndef PMCRB_DEFINES_VH
`define PMCRB_DEFINES_VH

// Register sub-addresses
`define PMCRB_ADDR_UNLOCK 8'h10
`define PMCRB_ADDR_ENABLE2 8'h12
`define PMCRB_ADDR_PINSUP 8'h13
`define PMCRB_ADDR_RSTLIM 8'h14
`define PMCRB_ADDR_PFDCH 8'h15

// Reset values
`define PMCRB_RST_PINSUP 8'h48
`define PMCRB_RST_RSTLIM 8'hC0
`define PMCRB_RST_PFDCH 8'h00

// Writable-bit masks; other bits are reserved and read zero
`define PMCRB_MASK_PINSUP 8'hFF
`define PMCRB_MASK_RSTLIM 8'hCF
`define PMCRB_MASK_PFDCH 8'h3F

// Unlock key value that arms the next write, whatever its address
`define PMCRB_UNLOCK_KEY 8'h7D

// Field positions, pin-and-supervisor register
`define PMCRB_BIT_RST_TIME 7
`define PMCRB_BIT_OUT2_PP 6
`define PMCRB_BIT_IO1_ROLE 5
`define PMCRB_BIT_PGD_HI 4
`define PMCRB_BIT_PGD_LO 3
`define PMCRB_BIT_TIGHT 2
// Field positions, reset-pin and limit register
`define PMCRB_BIT_WARM_RST 7
`define PMCRB_BIT_HYST 6

// Power-good delays in ms and in cycles at 200 MHz (5 ns)
`define PMCRB_CLK_PERIOD_NS 5
`define PMCRB_PGD_MS0 10
`define PMCRB_PGD_MS1 20
`define PMCRB_PGD_MS2 50
`define PMCRB_PGD_MS3 150
`define PMCRB_MS_CYCLES (1000000 / `PMCRB_CLK_PERIOD_NS)

// Push-button hold times in s
`define PMCRB_HOLD_S_SHORT 8
`define PMCRB_HOLD_S_LONG 15
`endif

/* verilog/pmcrb_pgood_delay.v */
// Power-good rising-edge delay; falling edges pass at once.
// Assumes i_pgood_raw is synchronous to i_ref_clk.
`timescale 1ns/1ps
module pmcrb_pgood_delay #(
  parameter [31:0] DLY0 = 32'd2000000,
  parameter [31:0] DLY1 = 32'd4000000,
  parameter [31:0] DLY2 = 32'd10000000,
  parameter [31:0] DLY3 = 32'd30000000
) (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire [1:0] i_sel,
  input wire i_pgood_raw,
  output wire o_pgood
);
  reg [31:0] cnt_r;
  reg pg_r;
  reg [31:0] limit;

  // Code to delay count
  always @* begin
    case (i_sel)
      2'b00: limit = DLY0;
      2'b01: limit = DLY1;
      2'b10: limit = DLY2;
      default: limit = DLY3;
    endcase
  end

  // Count while raw stays high; drop immediately on any fall
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cnt_r <= 32'h0;
      pg_r <= 1'b0;
    end else if (!i_pgood_raw) begin
      cnt_r <= 32'h0;
      pg_r <= 1'b0;
    end else if (!pg_r) begin
      if (cnt_r + 32'h1 >= limit) begin
        pg_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end

  assign o_pgood = pg_r;
endmodule // pmcrb_pgood_delay

/* test/pmcrb_properties.sv */
// Port checks for the configuration bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module pmcrb_chk (
  input wire i_ref_clk, input wire i_nrst, input wire i_wr, input wire i_rd,
  input wire [7:0] i_addr, input wire [7:0] i_wdata, input wire [7:0] o_rdata,
  input wire o_wr_rejected, input wire [2:0] i_ls_en, input wire i_power_fail_flag_n,
  input wire [2:0] o_ls_on, input wire [2:0] o_ls_discharge, input wire i_pgood_raw,
  input wire o_pgood, input wire o_tight_thresholds, input wire o_ov_monitor_en,
  input wire o_buck12_warm_reset, input wire o_io_pin_three_oe_n,
  input wire i_io_pin_three_in
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  reg arm_r;
  // Only the key write arms the next write; any other write disarms it
  always @(posedge i_ref_clk) begin
    if (!i_nrst) arm_r <= 1'b0;
    else if (i_wr) arm_r <= (i_addr == 8'h10) && (i_wdata == 8'h7D);
  end
  //////////
  sequence s_bad_wr; i_wr && i_addr >= 8'h13 && i_addr <= 8'h15 && !arm_r; endsequence
  sequence s_key_rd; i_rd && i_addr == 8'h10; endsequence
  chk_locked_drop: assert property (s_bad_wr |=> o_wr_rejected)
    else $error("unkeyed write not refused");
  chk_key_zero: assert property (s_key_rd |=> o_rdata == 8'h00)
    else $error("key register read not zero");
  chk_reserved_zero: assert property (i_rd && i_addr == 8'h15 |=> !o_rdata[7:6])
    else $error("reserved bits not zero");
  chk_pf_pass: assert property (i_power_fail_flag_n |-> o_ls_on == i_ls_en)
    else $error("switch off without power fail");
  chk_ls_subset: assert property ((o_ls_on & ~i_ls_en) == 3'h0)
    else $error("switch on while not enabled");
  chk_dch_off: assert property ((o_ls_discharge & o_ls_on) == 3'h0)
    else $error("discharge on a live switch");
  chk_pg_fall: assert property (!i_pgood_raw |=> !o_pgood)
    else $error("falling power good delayed");
  chk_pg_rise: assert property ($rose(o_pgood) |-> $past(i_pgood_raw, 2))
    else $error("power good rose without cause");
  chk_sup_pair: assert property (o_ov_monitor_en == o_tight_thresholds)
    else $error("overvoltage watch differs from strictness");
  chk_io3_input: assert property (o_buck12_warm_reset |-> o_io_pin_three_oe_n && !i_io_pin_three_in)
    else $error("warm reset with pin driven or high");
endmodule // pmcrb_chk
bind pmcrb_config_bank pmcrb_chk u_chk (.*);

/* test/pmcrb_host.sv */
// Host model of the register port: byte writes, keyed writes, reads.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ps
module pmcrb_host (
  input wire i_ref_clk,
  input wire [7:0] i_rdata,
  output reg o_wr = 1'b0,
  output reg o_rd = 1'b0,
  output reg [7:0] o_addr = 8'h00,
  output reg [7:0] o_wdata = 8'h00
);
  // Released address and data flip so nothing leans on stale values
  task wr8(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_ref_clk) {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
      @(posedge i_ref_clk) {o_wr, o_addr, o_wdata} <= {1'b0, ~a, ~d};
    end
  endtask
  //////////
  task pwr8(input [7:0] a, input [7:0] d);
    begin
      wr8(8'h10, 8'h7D);
      wr8(a, d);
    end
  endtask
  // Read data is taken the cycle after the strobe
  task rd8(input [7:0] a, output [7:0] d);
    begin
      @(posedge i_ref_clk) {o_rd, o_addr} <= {1'b1, a};
      @(posedge i_ref_clk) {o_rd, o_addr} <= {1'b0, ~a};
      #1 d = i_rdata;
    end
  endtask
endmodule // pmcrb_host

/* test/pmcrb_config_bank_tb.sv */
// Self-checking bench for the protected configuration bank.
// Assumes the host model drives the port; the pgood delay is never waited out.
`timescale 1ns/1ps
module pmcrb_config_bank_tb;
  reg clk = 1'b0, nrst = 1'b0, pfn = 1'b1, pg = 1'b0, io1 = 1'b0, io3 = 1'b0;
  reg [2:0] ls_en = 3'h0, en2 = 3'h0;
  reg [7:0] r;
  wire wr, rs, rej, io1n, p2o, p2n, io3o, io3n, wrst, pgo, h15, tgt, ov, hys, io1o;
  wire [1:0] uvl;
  wire [7:0] a, wd, rdat;
  wire [1:0] l3, l2;
  wire [2:0] lson, dch;
  wire [7:0] st = {h15, tgt, ov, hys, l3, l2};
  wire [7:0] pins = {2'h0, io1n, p2n, p2o, io3n, wrst, pgo};
  integer err_total = 0, compares = 0, i, cyc = 0;
  pmcrb_host host (.i_ref_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rs), .o_addr(a),
    .o_wdata(wd));
  pmcrb_config_bank uut (.i_ref_clk(clk), .i_nrst(nrst), .i_wr(wr), .i_rd(rs),
    .i_addr(a), .i_wdata(wd), .o_rdata(rdat), .o_wr_rejected(rej), .i_ls_en(ls_en),
    .i_power_fail_flag_n(pfn), .i_pgood_raw(pg), .i_io_pin_one_in(io1),
    .i_io_pin_three_in(io3), .i_en2_pin_bits(en2), .o_io_pin_one_out(io1o),
    .o_io_pin_one_oe_n(io1n), .o_out_pin_two_out(p2o), .o_out_pin_two_oe_n(p2n),
    .o_io_pin_three_out(io3o), .o_io_pin_three_oe_n(io3n), .o_buck12_warm_reset(wrst),
    .o_pgood(pgo), .o_hold_15s(h15), .o_tight_thresholds(tgt), .o_ov_monitor_en(ov),
    .o_undervoltage_lockout_level(uvl), .o_lockout_hysteresis_sel(hys),
    .o_switch3_current_limit(l3), .o_switch2_current_limit(l2), .o_ls_on(lson),
    .o_ls_discharge(dch));
  initial forever #2.5 clk = ~clk;
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task final_report;
    begin
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      final_report;
    end
  end
  //////////
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    host.rd8(8'h13, r); chk("cfg1", 8'h48, r);
    host.rd8(8'h14, r); chk("cfg2", 8'hC0, r);
    chk("stat", 8'h10, st);
    chk("pins", 8'h06, pins);
    host.wr8(8'h15, 8'h3F); #1 chk("rej", 8'h01, {7'h0, rej});
    host.rd8(8'h15, r); chk("cfg3", 8'h00, r);
    host.pwr8(8'h15, 8'hFF); host.rd8(8'h15, r); chk("cfg3", 8'h3F, r);
    @(posedge clk) {ls_en, pfn} <= 4'hE; #1 chk("ls", 8'h07, {2'h0, lson, dch});
    @(posedge clk) pfn <= 1'b1; #1 chk("ls", 8'h38, {2'h0, lson, dch});
    host.pwr8(8'h15, 8'h07); @(posedge clk) {ls_en, pfn} <= 4'hA;
    #1 chk("ls", 8'h2A, {2'h0, lson, dch});
    for (i = 0; i < 4; i = i + 1) begin
      host.pwr8(8'h14, {4'h3, i[1:0], i[1:0]}); host.rd8(8'h14, r);
      chk("cfg2", {4'h0, i[1:0], i[1:0]}, r);
      chk("stat", {4'h0, i[1:0], i[1:0]}, st);
    end
    chk("pins", 8'h00, pins); chk("io3", 8'h00, {7'h0, io3o});
    chk("io1", 8'h00, {7'h0, io1o});
    @(posedge clk) en2 <= 3'h4; #1 chk("pins", 8'h04, pins);
    host.pwr8(8'h14, 8'h80); @(posedge clk) en2 <= 3'h0; #1 chk("pins", 8'h06, pins);
    @(posedge clk) io3 <= 1'b1; #1 chk("pins", 8'h04, pins);
    host.pwr8(8'h13, 8'h04); #1 chk("stat", 8'h60, st);
    chk("pins", 8'h04, pins);
    host.pwr8(8'h13, 8'hE0); #1 chk("stat", 8'h80, st);
    chk("pins", 8'h24, pins);
    @(posedge clk) io1 <= 1'b1; #1 chk("pins", 8'h2C, pins);
    host.rd8(8'h10, r); chk("key", 8'h00, r);
    host.pwr8(8'h13, 8'hE3); #1 chk("undervoltage_lockout_level", 8'h03, {6'h0, uvl});
    @(posedge clk) pg <= 1'b1; repeat (5) @(posedge clk);
    #1 chk("pgood", 8'h00, {7'h0, pgo});
    @(posedge clk) pg <= 1'b0; @(posedge clk); #1 chk("pgood", 8'h00, {7'h0, pgo});
    final_report;
  end
endmodule // pmcrb_config_bank_tb
